// File: rtl/adm_defines.vh
// Timing and layout constants for the asynchronous DRAM module controller.
`ifndef ADM_DEFINES_VH
`define ADM_DEFINES_VH
`define ADM_CLK_PERIOD_PS    5000
`define ADM_ROW_BITS         12
`define ADM_COL_BITS         11
`define ADM_ADDR_LINES       11
`define ADM_DATA_BITS        32
`define ADM_LANES            4
`define ADM_T_PWRUP_US       200
`define ADM_PWRUP_CYC \
    ((`ADM_T_PWRUP_US * 1000000 + `ADM_CLK_PERIOD_PS - 1) / `ADM_CLK_PERIOD_PS)
`define ADM_INIT_CYCLES      8
`define ADM_REF_ROWS         2048
`define ADM_T_REF_MS         32
// The interval is formed in ns first so no product leaves 32 bits.
`define ADM_REF_INT_CYC \
    ((`ADM_T_REF_MS * 1000000 / `ADM_REF_ROWS) * 1000 / `ADM_CLK_PERIOD_PS)
`define ADM_T_RC_FAST_NS     90
`define ADM_T_RC_SLOW_NS     110
`define ADM_T_PC_FAST_NS     35
`define ADM_T_PC_SLOW_NS     40
`define ADM_T_RP_NS          40
`define ADM_T_RCD_NS         20
`define ADM_T_CAS_NS         15
`define ADM_T_CP_NS          10
`define ADM_T_CSR_NS         10
`define ADM_T_ACC_NS         60
`define ADM_NS2CYC(t) \
    (((t) * 1000 + `ADM_CLK_PERIOD_PS - 1) / `ADM_CLK_PERIOD_PS)
`define ADM_SPEED_FAST       4'h1
`define ADM_SPEED_SLOW       4'hd
`endif

// File: rtl/adm_sync2.v
// Two-flop synchroniser for a bus of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module adm_sync2 #(
    parameter W = 1
) (
    input  wire         sys_clk_i,
    input  wire         nrst_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
        end else begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
        end
    end
    assign q_o = s2_ff;
endmodule // adm_sync2
`default_nettype wire

// File: rtl/adm_ctrl.v
// Host controller that drives the asynchronous DRAM module strobes.
//
// Behaviour
// - For 16-bit use the board ties each low data line to the one 16 above.
// - Every write is early: write line low before the column strobe falls.
// - The controller issues 2048 refreshes in every 32 ms.
// - After power-up wait 200 us, then 8 row-strobe cycles with a refresh.
// - With the internal counter the 8 start-up cycles are column-before-row.
// - A read holds the write line high until a column or row strobe rises.
// - Random cycles are at least 90 ns or 110 ns apart by speed grade.
// - Page column accesses are at least 35 ns or 40 ns apart by grade.
`timescale 1ns/1ps
`default_nettype none
`include "adm_defines.vh"
module adm_ctrl #(
    parameter PWRUP_CYC   = `ADM_PWRUP_CYC,
    parameter REF_INT_CYC = `ADM_REF_INT_CYC
) (
    input  wire        sys_clk_i,
    input  wire        nrst_i,
    input  wire        req_valid_i,
    input  wire        req_write_i,
    input  wire [22:0] req_addr_i,
    input  wire [31:0] req_wdata_i,
    input  wire [3:0]  req_be_i,
    output reg         req_ready_o,
    output reg         rd_valid_o,
    output reg  [31:0] rd_data_o,
    output reg         init_done_o,
    output reg         grade_slow_o,
    output reg  [3:0]  row_strobe_n_o,
    output reg  [3:0]  column_strobe_n_o,
    output reg         write_n_o,
    output reg  [10:0] mux_address_o,
    output reg  [31:0] shared_data_lines_o,
    output reg         shared_data_lines_oe_n_o,
    input  wire [31:0] shared_data_lines_i,
    input  wire [3:0]  speed_code_i
);
    localparam CW = 16;
    localparam [CW-1:0] RC_F  = `ADM_NS2CYC(`ADM_T_RC_FAST_NS);
    localparam [CW-1:0] RC_S  = `ADM_NS2CYC(`ADM_T_RC_SLOW_NS);
    localparam [CW-1:0] PC_F  = `ADM_NS2CYC(`ADM_T_PC_FAST_NS);
    localparam [CW-1:0] PC_S  = `ADM_NS2CYC(`ADM_T_PC_SLOW_NS);
    localparam [CW-1:0] T_RP  = `ADM_NS2CYC(`ADM_T_RP_NS);
    localparam [CW-1:0] T_RCD = `ADM_NS2CYC(`ADM_T_RCD_NS);
    localparam [CW-1:0] T_CAS = `ADM_NS2CYC(`ADM_T_CAS_NS);
    localparam [CW-1:0] T_CSR = `ADM_NS2CYC(`ADM_T_CSR_NS);
    localparam [CW-1:0] T_ACC = `ADM_NS2CYC(`ADM_T_ACC_NS);
    localparam [CW-1:0] T_CP  = `ADM_NS2CYC(`ADM_T_CP_NS);
    localparam [3:0] S_PWR  = 4'h_0;
    localparam [3:0] S_IDLE = 4'h_1;
    localparam [3:0] S_RAS  = 4'h_2;
    localparam [3:0] S_CAS  = 4'h_3;
    localparam [3:0] S_END  = 4'h_4;
    localparam [3:0] S_PRE  = 4'h_5;
    localparam [3:0] S_RCAS = 4'h_6;
    localparam [3:0] S_RRAS = 4'h_7;
    localparam [3:0] S_PAGE = 4'h_8;
    localparam [3:0] S_CPRE = 4'h_9;

    wire [3:0]  spd_s;
    wire [31:0] dq_s;
    adm_sync2 #(.W(4)) u_spd (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .d_i       (speed_code_i),
        .q_o       (spd_s)
    );
    adm_sync2 #(.W(32)) u_dq (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .d_i       (shared_data_lines_i),
        .q_o       (dq_s)
    );

    reg [3:0]    st_ff;
    reg [31:0]   pw_ff;
    reg [31:0]   rf_ff;
    reg [CW-1:0] t_ff;
    reg [CW-1:0] cyc_ff;
    reg [3:0]    init_ff;
    reg          ref_pend_ff;
    reg          wr_ff;
    reg [11:0]   row_ff;
    reg          row_open_ff;
    reg [10:0]   col_ff;
    reg [3:0]    be_ff;
    reg [CW-1:0] pg_ff;

    // Slow grade is taken from speed_code pin 2 alone, released high.
    wire slow = spd_s[2];
    // The slower timing is used while the grade changes, so the reported
    // grade always covers the cycle being timed.
    wire use_slow = slow | grade_slow_o;
    wire [CW-1:0] rc = use_slow ? RC_S : RC_F;
    wire [CW-1:0] pc = use_slow ? PC_S : PC_F;
    wire [11:0] req_row = req_addr_i[22:11];
    wire [3:0] rsel = req_row[11] ? 4'b_1100 : 4'b_0011;
    wire page_hit = row_open_ff && (req_row == row_ff);

    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st_ff <= S_PWR;
            pw_ff <= 32'h_0000_0000;
            rf_ff <= 32'h_0000_0000;
            t_ff <= {CW{1'b0}};
            cyc_ff <= {CW{1'b0}};
            init_ff <= 4'h_0;
            ref_pend_ff <= 1'b0;
            wr_ff <= 1'b0;
            row_ff <= 12'h_000;
            row_open_ff <= 1'b0;
            col_ff <= 11'h_000;
            be_ff <= 4'h_0;
            pg_ff <= {CW{1'b0}};
            req_ready_o <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o <= 32'h_0000_0000;
            init_done_o <= 1'b0;
            grade_slow_o <= 1'b0;
            row_strobe_n_o <= 4'h_f;
            column_strobe_n_o <= 4'h_f;
            write_n_o <= 1'b1;
            mux_address_o <= 11'h_000;
            shared_data_lines_o <= 32'h_0000_0000;
            shared_data_lines_oe_n_o <= 1'b1;
        end else begin
            rd_valid_o <= 1'b0;
            req_ready_o <= 1'b0;
            grade_slow_o <= slow;
            t_ff <= t_ff + {{(CW-1){1'b0}}, 1'b1};
            cyc_ff <= cyc_ff + {{(CW-1){1'b0}}, 1'b1};
            pg_ff <= pg_ff + {{(CW-1){1'b0}}, 1'b1};
            case (st_ff)
            S_PWR: begin
                if (pw_ff < PWRUP_CYC) begin
                    pw_ff <= pw_ff + 32'h_0000_0001;
                end else if (cyc_ff >= rc) begin
                    st_ff <= S_RCAS;
                    column_strobe_n_o <= 4'h_0;
                    t_ff <= {CW{1'b0}};
                end
            end
            S_IDLE: begin
                if (ref_pend_ff) begin
                    row_strobe_n_o <= 4'h_f;
                    column_strobe_n_o <= 4'h_f;
                    row_open_ff <= 1'b0;
                    if (row_open_ff) begin
                        st_ff <= S_PRE;
                        t_ff <= {CW{1'b0}};
                    end else if (cyc_ff >= rc) begin
                        ref_pend_ff <= 1'b0;
                        column_strobe_n_o <= 4'h_0;
                        st_ff <= S_RCAS;
                        t_ff <= {CW{1'b0}};
                    end
                end else if (req_valid_i && page_hit && pg_ff >= pc) begin
                    req_ready_o <= 1'b1;
                    wr_ff <= req_write_i;
                    be_ff <= req_be_i;
                    mux_address_o <= req_addr_i[10:0];
                    write_n_o <= ~req_write_i;
                    shared_data_lines_o <= req_wdata_i;
                    shared_data_lines_oe_n_o <= ~req_write_i;
                    st_ff <= S_PAGE;
                    t_ff <= {CW{1'b0}};
                end else if (req_valid_i && row_open_ff && !page_hit) begin
                    row_strobe_n_o <= 4'h_f;
                    row_open_ff <= 1'b0;
                    write_n_o <= 1'b1;
                    st_ff <= S_PRE;
                    t_ff <= {CW{1'b0}};
                end else if (req_valid_i && !row_open_ff && cyc_ff >= rc) begin
                    req_ready_o <= 1'b1;
                    wr_ff <= req_write_i;
                    be_ff <= req_be_i;
                    row_ff <= req_row;
                    col_ff <= req_addr_i[10:0];
                    // Write data is taken with the request and only driven
                    // once the column phase starts.
                    shared_data_lines_o <= req_wdata_i;
                    mux_address_o <= req_row[10:0];
                    row_strobe_n_o <= ~rsel;
                    row_open_ff <= 1'b1;
                    cyc_ff <= {CW{1'b0}};
                    st_ff <= S_RAS;
                    t_ff <= {CW{1'b0}};
                end
            end
            S_RAS: begin
                if (t_ff >= T_RCD - 1) begin
                    mux_address_o <= col_ff;
                    write_n_o <= ~wr_ff;
                    shared_data_lines_oe_n_o <= ~wr_ff;
                    st_ff <= S_PAGE;
                    t_ff <= {CW{1'b0}};
                end
            end
            S_PAGE: begin
                // Write enable and data settle one cycle before the strobe.
                column_strobe_n_o <= wr_ff ? ~be_ff : 4'h_0;
                pg_ff <= {CW{1'b0}};
                st_ff <= S_CAS;
                t_ff <= {CW{1'b0}};
            end
            S_CAS: begin
                if (t_ff >= (T_ACC > T_CAS ? T_ACC : T_CAS)) begin
                    if (!wr_ff) begin
                        // A board with the halves tied reads both alike.
                        rd_data_o <= dq_s;
                        rd_valid_o <= 1'b1;
                    end
                    column_strobe_n_o <= 4'h_f;
                    st_ff <= S_CPRE;
                    t_ff <= {CW{1'b0}};
                end
            end
            S_CPRE: begin
                // Read command stays high past the column strobe rise.
                if (t_ff >= T_CP - 1) begin
                    write_n_o <= 1'b1;
                    shared_data_lines_oe_n_o <= 1'b1;
                    st_ff <= S_IDLE;
                end
            end
            S_PRE: begin
                if (t_ff >= T_RP - 1) begin
                    st_ff <= S_IDLE;
                end
            end
            S_RCAS: begin
                if (t_ff >= T_CSR - 1) begin
                    row_strobe_n_o <= 4'h_0;
                    st_ff <= S_RRAS;
                    t_ff <= {CW{1'b0}};
                    cyc_ff <= {CW{1'b0}};
                end
            end
            S_RRAS: begin
                if (t_ff >= T_CSR - 1) begin
                    column_strobe_n_o <= 4'h_f;
                end
                if (cyc_ff >= rc - T_RP) begin
                    row_strobe_n_o <= 4'h_f;
                    if (!init_done_o && init_ff < `ADM_INIT_CYCLES - 1) begin
                        init_ff <= init_ff + 4'h_1;
                        st_ff <= S_PWR;
                    end else begin
                        init_done_o <= 1'b1;
                        st_ff <= S_IDLE;
                    end
                end
            end
            default: begin
                st_ff <= S_IDLE;
            end
            endcase
            // After the state machine, so a new request wins over the
            // clear when both fall in one cycle.
            if (rf_ff >= REF_INT_CYC - 1) begin
                rf_ff <= 32'h_0000_0000;
                ref_pend_ff <= 1'b1;
            end else if (init_done_o) begin
                rf_ff <= rf_ff + 32'h_0000_0001;
            end
        end
    end
endmodule // adm_ctrl
`default_nettype wire

// File: verif/adm_ctrl_assertions.sv
// Strobe timing checker for the DRAM module controller.
`timescale 1ns/1ps
`default_nettype none
module adm_ctrl_chk #(
    parameter PWRUP_CYC   = 50,
    parameter REF_INT_CYC = 200
) (
    input wire logic       sys_clk_i,
    input wire logic       nrst_i,
    input wire logic       req_valid_i,
    input wire logic [3:0] req_be_i,
    input wire logic       req_ready_o,
    input wire logic       init_done_o,
    input wire logic       grade_slow_o,
    input wire logic [3:0] row_strobe_n_o,
    input wire logic [3:0] column_strobe_n_o,
    input wire logic       write_n_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    logic        row_ff, col_ff;
    logic [7:0]  rc_ff, pc_ff;
    logic [15:0] up_ff, ref_ff;
    logic [3:0]  be_ff, be_q_ff;
    wire         row_lo = row_strobe_n_o != 4'hf;
    wire         col_lo = column_strobe_n_o != 4'hf;
    wire         row_fall = row_lo && !row_ff;
    wire         col_fall = col_lo && !col_ff;
    always_ff @(posedge sys_clk_i) begin
        row_ff <= row_lo;
        col_ff <= col_lo;
        // Ready trails the take edge by one cycle, so the enables of that
        // edge are kept one cycle longer.
        be_q_ff <= req_be_i;
        if (req_ready_o) be_ff <= be_q_ff;
        if (!nrst_i) begin
            {rc_ff, pc_ff} <= 16'hffff;
            {up_ff, ref_ff} <= '0;
        end else begin
            rc_ff <= row_fall ? 8'h1 : rc_ff + {7'h0, rc_ff != 8'hff};
            pc_ff <= col_fall ? 8'h1 : pc_ff + {7'h0, pc_ff != 8'hff};
            up_ff <= up_ff + {15'h0, up_ff != 16'hffff};
            ref_ff <= row_fall && col_lo ? 16'h0 : ref_ff + 16'h1;
        end
    end
    sequence s_col_write; !write_n_o && !col_lo ##1 col_fall; endsequence
    property p_early; col_fall && !write_n_o |-> !$past(write_n_o); endproperty
    a_early: assert property (p_early)
        else $error("write line late for column strobe");
    property p_we_hold; col_lo && col_ff |-> $stable(write_n_o); endproperty
    a_we_hold: assert property (p_we_hold)
        else $error("write line moved under column strobe");
    property p_rc; row_fall |-> rc_ff >= (grade_slow_o ? 22 : 18); endproperty
    a_rc: assert property (p_rc)
        else $error("random cycle too short");
    property p_pc; col_fall |-> pc_ff >= (grade_slow_o ? 8 : 7); endproperty
    a_pc: assert property (p_pc)
        else $error("page cycle too short");
    property p_cbr; row_fall && col_lo |->
        $past(column_strobe_n_o, 2) == 4'h0 && write_n_o; endproperty
    a_cbr: assert property (p_cbr)
        else $error("refresh strobe order wrong");
    property p_init; row_fall && !init_done_o |->
        col_lo && up_ff >= PWRUP_CYC; endproperty
    a_init: assert property (p_init)
        else $error("start-up cycle wrong");
    property p_ref; init_done_o |-> ref_ff < REF_INT_CYC + 96; endproperty
    a_ref: assert property (p_ref)
        else $error("refresh overdue");
    property p_be; s_col_write |-> row_lo && column_strobe_n_o == ~be_ff;
    endproperty
    a_be: assert property (p_be)
        else $error("write lanes differ from byte enables");
endmodule // adm_ctrl_chk

bind adm_ctrl adm_ctrl_chk #(
    .PWRUP_CYC(PWRUP_CYC),
    .REF_INT_CYC(REF_INT_CYC)
) u_chk (
    .sys_clk_i, .nrst_i, .req_valid_i, .req_be_i, .req_ready_o,
    .init_done_o, .grade_slow_o, .row_strobe_n_o, .column_strobe_n_o,
    .write_n_o
);
`default_nettype wire

// File: verif/adm_dram_model.sv
// Cycle-sampled model of the 32-bit DRAM module on the controller pins.
`timescale 1ns/1ps
`default_nettype none
module adm_dram_model (
    input  wire logic        sys_clk_i,
    input  wire logic        slow_i,
    input  wire logic [3:0]  row_strobe_n_i,
    input  wire logic [3:0]  column_strobe_n_i,
    input  wire logic        write_n_i,
    input  wire logic [10:0] mux_address_i,
    input  wire logic [31:0] ctrl_data_i,
    input  wire logic        ctrl_oe_n_i,
    output logic      [31:0] bus_o,
    output logic      [3:0]  speed_code_o
);
    bit   [31:0] mem [bit [22:0]];
    bit   [31:0] w;
    logic [11:0] row_ff;
    logic [3:0]  col_ff = 4'hf;
    logic        rlo_ff = 1'b0;
    logic [31:0] rd_ff = '0, last_ff = '0;
    wire         row_lo = row_strobe_n_i != 4'hf;
    wire  [22:0] a = {row_ff, mux_address_i};
    wire         drv = row_lo && column_strobe_n_i != 4'hf && write_n_i;
    assign speed_code_o = slow_i ? 4'hd : 4'h1;
    // Released pins show the inverse of the last value, never a stale copy.
    assign bus_o = !ctrl_oe_n_i ? ctrl_data_i : drv ? rd_ff : ~last_ff;
    always @(posedge sys_clk_i) begin
        last_ff <= bus_o;
        rlo_ff <= row_lo;
        col_ff <= column_strobe_n_i;
        if (row_lo && !rlo_ff) row_ff <= {!row_strobe_n_i[3], mux_address_i};
        if (row_lo && col_ff == 4'hf && column_strobe_n_i != 4'hf) begin
            w = mem.exists(a) ? mem[a] : '0;
            rd_ff <= w;
            for (int i = 0; i < 4; i++)
                if (!column_strobe_n_i[i]) w[8*i+:8] = bus_o[8*i+:8];
            if (!write_n_i) mem[a] = w;
        end
    end
endmodule // adm_dram_model
`default_nettype wire

// File: verif/adm_ctrl_test.sv
// Random and corner-case bench for the DRAM module controller.
`timescale 1ns/1ps
`default_nettype none
module adm_ctrl_test;
    logic        clk = 0, rst_n = 0, valid = 0, wr = 0, slow = 1;
    logic [22:0] addr = '0;
    logic [31:0] wdata = '0, rdata, bus, dq;
    logic [3:0]  be = 4'hf, rstb_n, cstb_n, code;
    logic [10:0] ma;
    logic        ready, rvld, done, gslow, we_n, oe_n;
    int          err_total = 0, num_checks = 0;
    bit   [31:0] shadow [bit [22:0]];
    initial forever #2.5 clk = ~clk;
    adm_ctrl #(.PWRUP_CYC(50), .REF_INT_CYC(200)) u_dut (
        .sys_clk_i(clk), .nrst_i(rst_n), .req_valid_i(valid), .req_be_i(be),
        .req_write_i(wr), .req_addr_i(addr), .req_wdata_i(wdata),
        .req_ready_o(ready), .rd_valid_o(rvld), .rd_data_o(rdata),
        .init_done_o(done), .grade_slow_o(gslow), .row_strobe_n_o(rstb_n),
        .column_strobe_n_o(cstb_n), .write_n_o(we_n), .mux_address_o(ma),
        .shared_data_lines_o(dq), .shared_data_lines_oe_n_o(oe_n),
        .shared_data_lines_i(bus), .speed_code_i(code));
    adm_dram_model u_mem (
        .sys_clk_i(clk), .slow_i(slow), .row_strobe_n_i(rstb_n),
        .column_strobe_n_i(cstb_n), .write_n_i(we_n), .mux_address_i(ma),
        .ctrl_data_i(dq), .ctrl_oe_n_i(oe_n), .bus_o(bus),
        .speed_code_o(code));
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask
    // Watched outputs: 0 ready, 1 write line, 2 read valid, 3 start-up done.
    function automatic logic watch(input int k);
        return k == 0 ? ready : k == 1 ? we_n : k == 2 ? rvld : done;
    endfunction
    task automatic wait_for(input int k, input logic v, input int lim);
        for (int n = 0; n < lim && watch(k) !== v; n++) @(posedge clk) #1;
        chk_bit(watch(k), v);
    endtask
    function automatic bit [31:0] merge(bit [31:0] o, d, bit [3:0] b);
        for (int i = 0; i < 4; i++) if (b[i]) o[8*i+:8] = d[8*i+:8];
        return o;
    endfunction
    task automatic access(input logic w, input logic [22:0] a,
                          input logic [3:0] b);
        valid = 1'b1;
        wr = w;
        addr = a;
        be = b;
        wdata = $urandom;
        wait_for(0, 1'b1, 400);
        valid = 1'b0;
        if (w) begin
            shadow[a] = merge(shadow.exists(a) ? shadow[a] : 0, wdata, b);
            wait_for(1, 1'b0, 40);
            wait_for(1, 1'b1, 40);
        end else begin
            wait_for(2, 1'b1, 100);
            chk_word(rdata, shadow.exists(a) ? shadow[a] : 0);
        end
        @(posedge clk) #1;
    endtask
    task automatic restart();
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 chk_bit(&{rstb_n, cstb_n, we_n, oe_n}, 1'b1);
        chk_bit(done, 1'b0);
        rst_n = 1'b1;
    endtask
    task automatic phase(input logic s);
        logic [22:0] a;
        slow = s;
        wait_for(3, 1'b1, 2000);
        repeat (4) @(posedge clk);
        #1 chk_bit(gslow, s);
        for (int i = 0; i < 40; i++) begin
            a = {1'($urandom), 11'($urandom % 3), 11'($urandom % 8)};
            if (i == 0) a = 23'h7f_ffff;
            access(1'($urandom), a,
                   i % 3 == 0 ? 4'(1 << i % 4) : 4'($urandom_range(15, 1)));
            access(1'b0, a, 4'hf);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hf2e9_8bfb));
        restart();
        phase(1'b1);
        phase(1'b0);
        restart();
        phase(1'b1);
        summarize();
    end
    initial begin
        #200_000;
        err_total++;
        summarize();
    end
endmodule // adm_ctrl_test
`default_nettype wire
